// ---- hw/lpm_pkg.sv ----
// Package holding the constants and types of the low-power mode clock gating block.
package lpm_pkg;
	typedef enum logic [3:0] {
		LPM_MODE_IDLE = 4'h1,
		LPM_MODE_CORE = 4'h2,
		LPM_MODE_CORE_PERIPH = 4'h4,
		LPM_MODE_ALL = 4'h8
	} lpm_mode_t;

	typedef enum logic [3:0] {
		LPM_ST_RUN = 4'h1,
		LPM_ST_SLEEP = 4'h2,
		LPM_ST_WAKE = 4'h4,
		LPM_ST_DONE = 4'h8
	} lpm_state_t;

	localparam int LPM_CLK_MHZ = 25;
	localparam int LPM_WAKE_IDLE_CYC = 2;
	localparam int LPM_WAKE_CORE_CYC = 2;
	localparam int LPM_WAKE_CORE_PERIPH_CYC = 6;
	localparam int LPM_WAKE_ALL_CYC = 500;
	localparam int LPM_CNT_W = 10;
	localparam logic [2:0] LPM_CTRL_RESET = 3'h0;
	localparam int LPM_BIT_STOP_CORE = 0;
	localparam int LPM_BIT_STOP_ALL = 1;
	localparam int LPM_BIT_POWER_DOWN_ALL_BIT_ALL = 2;
endpackage

// ---- hw/lpm_if.sv ----
// Interface joining the core sequencer end and the clock gating end.
`timescale 1ns/1ps
interface lpm_if;
	logic wait_insn;
	logic irq;
	logic [2:0] ctrl_bits;
	logic core_clk_en;
	logic periph_clk_en;
	logic mult_en;
	logic retain_pipe;
	logic sleeping;
	logic resume;
	lpm_pkg::lpm_mode_t mode;

	modport gate (
		input wait_insn,
		input irq,
		input ctrl_bits,
		output core_clk_en,
		output periph_clk_en,
		output mult_en,
		output retain_pipe,
		output sleeping,
		output resume,
		output mode
	);

	modport core (
		output wait_insn,
		output irq,
		output ctrl_bits,
		input core_clk_en,
		input periph_clk_en,
		input mult_en,
		input retain_pipe,
		input sleeping,
		input resume,
		input mode
	);
endinterface

// ---- hw/lpm_gate.sv ----
// Clock gating controller that enters and leaves the four standby modes.
`timescale 1ns/1ps
module lpm_gate (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	lpm_if.gate bus,
	output logic o_core_clk_en,
	output logic o_periph_clk_en,
	output logic o_mult_en
);
	lpm_pkg::lpm_state_t state;
	lpm_pkg::lpm_state_t next_state;
	lpm_pkg::lpm_mode_t mode;
	lpm_pkg::lpm_mode_t next_mode;
	lpm_pkg::lpm_mode_t gate_mode;
	logic [lpm_pkg::LPM_CNT_W-1:0] cnt;
	logic [lpm_pkg::LPM_CNT_W-1:0] wake_len;
	logic wake_last;
	logic next_core_en;
	logic next_periph_en;
	logic next_mult_en;
	logic next_retain;

	// Priority decode of the control bits at the moment of the wait instruction.
	always_comb begin
		if (bus.ctrl_bits[lpm_pkg::LPM_BIT_POWER_DOWN_ALL_BIT_ALL]) begin
			next_mode = lpm_pkg::LPM_MODE_ALL;
		end else if (bus.ctrl_bits[lpm_pkg::LPM_BIT_STOP_ALL]) begin
			next_mode = lpm_pkg::LPM_MODE_CORE_PERIPH;
		end else if (bus.ctrl_bits[lpm_pkg::LPM_BIT_STOP_CORE]) begin
			next_mode = lpm_pkg::LPM_MODE_CORE;
		end else begin
			next_mode = lpm_pkg::LPM_MODE_IDLE;
		end
	end

	// While running the live bits are decoded, so the enables drop on the very edge that takes the wait.
	always_comb begin
		if (state == lpm_pkg::LPM_ST_RUN) begin
			gate_mode = next_mode;
		end else begin
			gate_mode = mode;
		end
	end

	// Enable targets while asleep; a one keeps that clock, or the pipeline contents, alive.
	always_comb begin
		unique case (gate_mode)
			lpm_pkg::LPM_MODE_IDLE: begin
				next_core_en = 1'h1;
				next_periph_en = 1'h1;
				next_mult_en = 1'h1;
				next_retain = 1'h1;
			end
			lpm_pkg::LPM_MODE_CORE: begin
				next_core_en = 1'h0;
				next_periph_en = 1'h1;
				next_mult_en = 1'h1;
				next_retain = 1'h1;
			end
			lpm_pkg::LPM_MODE_CORE_PERIPH: begin
				next_core_en = 1'h0;
				next_periph_en = 1'h0;
				next_mult_en = 1'h1;
				next_retain = 1'h0;
			end
			lpm_pkg::LPM_MODE_ALL: begin
				next_core_en = 1'h0;
				next_periph_en = 1'h0;
				next_mult_en = 1'h0;
				next_retain = 1'h0;
			end
			default: begin
				next_core_en = 1'h1;
				next_periph_en = 1'h1;
				next_mult_en = 1'h1;
				next_retain = 1'h1;
			end
		endcase
	end

	// Wake latency of the latched mode, counted in core clock cycles from the interrupt.
	always_comb begin
		unique case (mode)
			lpm_pkg::LPM_MODE_IDLE: begin
				wake_len = lpm_pkg::LPM_CNT_W'(lpm_pkg::LPM_WAKE_IDLE_CYC);
			end
			lpm_pkg::LPM_MODE_CORE: begin
				wake_len = lpm_pkg::LPM_CNT_W'(lpm_pkg::LPM_WAKE_CORE_CYC);
			end
			lpm_pkg::LPM_MODE_CORE_PERIPH: begin
				wake_len = lpm_pkg::LPM_CNT_W'(lpm_pkg::LPM_WAKE_CORE_PERIPH_CYC);
			end
			lpm_pkg::LPM_MODE_ALL: begin
				wake_len = lpm_pkg::LPM_CNT_W'(lpm_pkg::LPM_WAKE_ALL_CYC);
			end
			default: begin
				wake_len = lpm_pkg::LPM_CNT_W'(lpm_pkg::LPM_WAKE_IDLE_CYC);
			end
		endcase
	end

	// The last wake cycle is reached when the count stands one short of the mode's latency.
	assign wake_last = cnt == wake_len - lpm_pkg::LPM_CNT_W'(1);

	always_comb begin
		next_state = state;
		unique case (state)
			lpm_pkg::LPM_ST_RUN: begin
				if (bus.wait_insn) begin
					next_state = lpm_pkg::LPM_ST_SLEEP;
				end
			end
			lpm_pkg::LPM_ST_SLEEP: begin
				if (bus.irq) begin
					next_state = lpm_pkg::LPM_ST_WAKE;
				end
			end
			lpm_pkg::LPM_ST_WAKE: begin
				if (wake_last) begin
					next_state = lpm_pkg::LPM_ST_DONE;
				end
			end
			lpm_pkg::LPM_ST_DONE: next_state = lpm_pkg::LPM_ST_RUN;
			default: next_state = lpm_pkg::LPM_ST_RUN;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= lpm_pkg::LPM_ST_RUN;
		end else begin
			state <= next_state;
		end
	end

	// The mode is latched only as the wait is taken, so later changes of the bits cannot alter a sleep.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode <= lpm_pkg::LPM_MODE_IDLE;
		end else if (state == lpm_pkg::LPM_ST_RUN && bus.wait_insn) begin
			mode <= next_mode;
		end
	end

	// Counts wake cycles from the interrupt; in full power-down it stands in for the multiplier settling time.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt <= '0;
		end else if (state == lpm_pkg::LPM_ST_WAKE) begin
			cnt <= cnt + lpm_pkg::LPM_CNT_W'(1);
		end else begin
			cnt <= '0;
		end
	end

	// Core clock enable; registered so the clock gate never sees a glitch from the mode decode.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_core_clk_en <= 1'h1;
		end else if (next_state == lpm_pkg::LPM_ST_SLEEP) begin
			o_core_clk_en <= next_core_en;
		end else if (next_state == lpm_pkg::LPM_ST_WAKE) begin
			o_core_clk_en <= 1'h1;
		end
	end

	// Peripheral clock enable; it stays up in the two modes that keep the peripheral bus alive.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_periph_clk_en <= 1'h1;
		end else if (next_state == lpm_pkg::LPM_ST_SLEEP) begin
			o_periph_clk_en <= next_periph_en;
		end else if (next_state == lpm_pkg::LPM_ST_WAKE) begin
			o_periph_clk_en <= 1'h1;
		end
	end

	// Multiplier enable; raising it at the interrupt lets the settling count run while it locks.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_mult_en <= 1'h1;
		end else if (next_state == lpm_pkg::LPM_ST_SLEEP) begin
			o_mult_en <= next_mult_en;
		end else if (next_state == lpm_pkg::LPM_ST_WAKE) begin
			o_mult_en <= 1'h1;
		end
	end

	// Pipeline retention is fixed as the wait is taken and restored once the core resumes.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bus.retain_pipe <= 1'h1;
		end else if (state == lpm_pkg::LPM_ST_RUN && bus.wait_insn) begin
			bus.retain_pipe <= next_retain;
		end else if (state == lpm_pkg::LPM_ST_DONE) begin
			bus.retain_pipe <= 1'h1;
		end
	end

	assign bus.sleeping = state != lpm_pkg::LPM_ST_RUN;
	assign bus.resume = state == lpm_pkg::LPM_ST_DONE;
	assign bus.mode = mode;
	assign bus.core_clk_en = o_core_clk_en;
	assign bus.periph_clk_en = o_periph_clk_en;
	assign bus.mult_en = o_mult_en;
endmodule

// ---- hw/lpm_core.sv ----
// Core sequencer end that issues the wait instruction with the selection bits and waits to resume.
`timescale 1ns/1ps
module lpm_core (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	lpm_if.core bus,
	input wire logic i_wait_req,
	input wire logic [2:0] i_ctrl_bits,
	input wire logic i_irq,
	input wire logic i_work_pending,
	output logic o_halted,
	output logic o_resumed,
	output logic o_flush
);
	logic [2:0] ctrl;
	logic halted;

	// Bits are held stable in a register so the gate samples settled values with the instruction.
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl <= lpm_pkg::LPM_CTRL_RESET;
		end else if (!halted) begin
			ctrl <= i_ctrl_bits;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			halted <= 1'b0;
		end else if (bus.resume) begin
			halted <= 1'b0;
		end else if (bus.wait_insn) begin
			halted <= 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_resumed <= 1'b0;
			o_flush <= 1'b0;
		end else begin
			o_resumed <= bus.resume;
			o_flush <= bus.resume && !bus.retain_pipe;
		end
	end

	// Power-down is withheld while work is pending, so a deep mode never strands service.
	assign bus.wait_insn = i_wait_req && !halted && (ctrl == lpm_pkg::LPM_CTRL_RESET || !i_work_pending);
	assign bus.ctrl_bits = ctrl;
	assign bus.irq = i_irq && halted;
	assign o_halted = halted;
endmodule

// ---- testbench/lpm_props.sv ----
// Checker of the rules on the wires between the core end and the gate end.
`timescale 1ns/1ps
module lpm_props (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic wait_insn,
	input wire logic irq,
	input wire logic [2:0] ctrl_bits,
	input wire logic core_clk_en,
	input wire logic periph_clk_en,
	input wire logic mult_en,
	input wire logic retain_pipe,
	input wire logic sleeping,
	input wire logic resume,
	input wire lpm_pkg::lpm_mode_t mode
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	wire go = wait_insn && !sleeping;
	wire [3:0] en = {core_clk_en, periph_clk_en, mult_en, retain_pipe};
	chk_idle_entry: assert property (go && ctrl_bits == 3'h0 |=> en == 4'hF)
		else $error("Idle entry changed a clock.");
	chk_core_entry: assert property (go && ctrl_bits == 3'h1 |=> en == 4'h7)
		else $error("Core power-down entry wrong.");
	chk_cp_entry: assert property (go && ctrl_bits[2:1] == 2'h1 |=> en == 4'h2)
		else $error("Core and peripheral entry wrong.");
	chk_all_entry: assert property (go && ctrl_bits[2] |=> en == 4'h0)
		else $error("Full power-down entry wrong.");
	chk_sleep_cause: assert property ($rose(sleeping) |-> $past(wait_insn))
		else $error("Sleep entered without a wait.");
	chk_wake_clocks: assert property ($rose(irq) && sleeping |=> en[3:1] == 3'h7)
		else $error("Clocks not restarted on wake.");
	chk_idle_wake: assert property ($rose(irq) && sleeping && mode == lpm_pkg::LPM_MODE_IDLE |-> ##3 resume)
		else $error("Idle wake latency wrong.");
	chk_core_wake: assert property ($rose(irq) && sleeping && mode == lpm_pkg::LPM_MODE_CORE |-> ##3 resume)
		else $error("Core wake latency wrong.");
	chk_cp_wake: assert property ($rose(irq) && sleeping && mode == lpm_pkg::LPM_MODE_CORE_PERIPH |-> ##7 resume)
		else $error("Core and peripheral wake latency wrong.");
	chk_all_wake: assert property ($rose(irq) && sleeping && mode == lpm_pkg::LPM_MODE_ALL |-> ##[501:501] resume)
		else $error("Full wake latency wrong.");
endmodule

// ---- testbench/tb.sv ----
// Testbench joining both ends and walking every standby mode.
`timescale 1ns/1ps
module tb;
	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_wait_req = 1'b0;
	logic [2:0] i_ctrl_bits = 3'h0;
	logic i_irq = 1'b0;
	logic i_work_pending = 1'b0;
	logic o_halted, o_resumed, o_flush, o_core_clk_en, o_periph_clk_en, o_mult_en;
	int fail_count = 0;
	int cmp_count = 0;
	int n;
	lpm_if bus ();
	lpm_gate i_lpm_gate (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .bus(bus), .o_core_clk_en(o_core_clk_en),
		.o_periph_clk_en(o_periph_clk_en), .o_mult_en(o_mult_en));
	lpm_core i_lpm_core (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .bus(bus), .i_wait_req(i_wait_req),
		.i_ctrl_bits(i_ctrl_bits), .i_irq(i_irq), .i_work_pending(i_work_pending), .o_halted(o_halted),
		.o_resumed(o_resumed), .o_flush(o_flush));
	lpm_props i_lpm_props (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .wait_insn(bus.wait_insn), .irq(bus.irq),
		.ctrl_bits(bus.ctrl_bits), .core_clk_en(bus.core_clk_en), .periph_clk_en(bus.periph_clk_en),
		.mult_en(bus.mult_en), .retain_pipe(bus.retain_pipe), .sleeping(bus.sleeping), .resume(bus.resume),
		.mode(bus.mode));
	initial begin
		forever #20 i_core_clk = ~i_core_clk;
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task test_done;
		if (fail_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// The enable word is core, peripheral, multiplier, then pipeline retention.
	task sleep(input logic [2:0] c, input logic [3:0] m, input logic [3:0] en, input int wk);
		@(negedge i_core_clk) i_ctrl_bits = c;
		@(negedge i_core_clk) i_wait_req = 1'b1;
		@(negedge i_core_clk) i_wait_req = 1'b0;
		chk({o_halted, bus.mode, o_core_clk_en, o_periph_clk_en, o_mult_en, bus.retain_pipe}, {1'b1, m, en});
		@(negedge i_core_clk) i_irq = 1'b1;
		n = 0;
		do begin
			@(negedge i_core_clk);
			n++;
		end while (o_resumed !== 1'b1 && n < 600);
		chk(16'(n), 16'(wk + 2));
		chk({15'h0, o_flush}, {15'h0, !en[0]});
		@(negedge i_core_clk) i_irq = 1'b0;
	endtask
	initial begin
		repeat (20) @(negedge i_core_clk);
		i_rst_n = 1'b1;
		sleep(3'h0, lpm_pkg::LPM_MODE_IDLE, 4'hF, lpm_pkg::LPM_WAKE_IDLE_CYC);
		sleep(3'h1, lpm_pkg::LPM_MODE_CORE, 4'h7, lpm_pkg::LPM_WAKE_CORE_CYC);
		sleep(3'h3, lpm_pkg::LPM_MODE_CORE_PERIPH, 4'h2, lpm_pkg::LPM_WAKE_CORE_PERIPH_CYC);
		sleep(3'h2, lpm_pkg::LPM_MODE_CORE_PERIPH, 4'h2, lpm_pkg::LPM_WAKE_CORE_PERIPH_CYC);
		sleep(3'h7, lpm_pkg::LPM_MODE_ALL, 4'h0, lpm_pkg::LPM_WAKE_ALL_CYC);
		sleep(3'h4, lpm_pkg::LPM_MODE_ALL, 4'h0, lpm_pkg::LPM_WAKE_ALL_CYC);
		i_work_pending = 1'b1;
		@(negedge i_core_clk) i_ctrl_bits = 3'h4;
		@(negedge i_core_clk) i_wait_req = 1'b1;
		@(negedge i_core_clk) i_wait_req = 1'b0;
		@(negedge i_core_clk);
		chk({15'h0, o_halted}, 16'h0000);
		sleep(3'h0, lpm_pkg::LPM_MODE_IDLE, 4'hF, lpm_pkg::LPM_WAKE_IDLE_CYC);
		test_done;
	end
	// The longest run is two full wakes of about five hundred cycles each.
	initial begin
		#200us;
		fail_count++;
		test_done;
	end
endmodule
